// *** rsc_regs.vh ***
// Constants of the reset source controller: register offsets, fields,
// reset values and timing counts.
// Assumes a 10 MHz system clock and a byte-addressed register port.
`ifndef RSC_REGS_VH
`define RSC_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define RSC_ADDR_W          8
`define RSC_OFS_SRST0       8'h00
`define RSC_OFS_SRST1       8'h04
`define RSC_OFS_SRST2       8'h08
`define RSC_OFS_SUPCTL      8'h0C
`define RSC_OFS_SYSREQ      8'h10
`define RSC_OFS_CAUSE       8'h14
`define RSC_OFS_WDLOAD      8'h18
`define RSC_OFS_WDVALUE     8'h1C
`define RSC_OFS_WDCTL       8'h20
`define RSC_OFS_WDICR       8'h24
`define RSC_OFS_STATUS      8'h28

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RSC_SUP_EN          0
`define RSC_SUP_RSTSEL      1
`define RSC_SYSREQ_BIT      0
`define RSC_CAUSE_W         5
`define RSC_CAUSE_POR       0
`define RSC_CAUSE_EXT       1
`define RSC_CAUSE_DROP      2
`define RSC_CAUSE_WDT       3
`define RSC_CAUSE_SW        4
`define RSC_WDCTL_EN        0
`define RSC_WDCTL_RSTEN     1
`define RSC_WDICR_FLAG      0
`define RSC_ST_DROP_IRQ     0
`define RSC_ST_CORE_RUN     1
`define RSC_ST_TAP_RUN      2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RSC_ZERO32          32'h0000_0000
`define RSC_ONES32          32'hFFFF_FFFF
`define RSC_WDLOAD_RST      32'hFFFF_FFFF
`define RSC_SUPCTL_RST      2'h0
`define RSC_WDCTL_RST       2'h0
`define RSC_CAUSE_RST       5'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RSC_CLK_PERIOD_NS   100
`define RSC_PULSE_NS        800
`define RSC_PULSE_CYC       ((`RSC_PULSE_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_PULSE_CW        4

// ----------------------------------------------------------------------
// Boot fetch states
// ----------------------------------------------------------------------
`define RSC_BOOT_W          3
`define RSC_FETCH_SP        2'h0
`define RSC_FETCH_PC        2'h1
`define RSC_FETCH_INSN      2'h2

`endif

// *** rsc_reset_ctrl.v ***
// Reset source controller: combines power-on, pin, supply-drop, software
// and watchdog resets into core, peripheral and test-port resets, then
// steps the boot fetch sequence.
// Assumes a 10 MHz clock that runs through reset and a simple strobe bus.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/10ps
`include "rsc_regs.vh"

module rsc_reset_ctrl (
    // Clock and block reset
    input  wire                     i_clk_sys,
    input  wire                     i_resetn,
    // Reset sources
    input  wire                     i_por_active,
    input  wire                     i_ext_rst_n,
    input  wire                     i_supply_low,
    // Register port
    input  wire [`RSC_ADDR_W-1:0]   i_addr,
    input  wire [31:0]              i_wdata,
    input  wire                     i_wr,
    input  wire                     i_rd,
    output reg  [31:0]              o_rdata,
    // Resets out
    output wire                     o_core_rst_n,
    output wire                     o_tap_rst_n,
    output reg  [95:0]              o_periph_rst_n,
    // Boot fetch sequence
    output reg                      o_fetch_valid,
    output reg  [1:0]               o_fetch_kind,
    output reg                      o_cpu_run,
    // Event outputs
    output reg                      o_supply_drop_irq,
    output reg                      o_wdt_irq
);

    // ------------------------------------------------------------------
    // Boot states
    // ------------------------------------------------------------------
    localparam [2:0] ST_HOLD = 3'd0;
    localparam [2:0] ST_SP   = 3'd1;
    localparam [2:0] ST_PC   = 3'd2;
    localparam [2:0] ST_INSN = 3'd3;
    localparam [2:0] ST_RUN  = 3'd4;

    function hit;
        input [`RSC_ADDR_W-1:0] addr;
        input [`RSC_ADDR_W-1:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg        por_s1_ff, por_s2_ff;
    reg        ext_s1_ff, ext_s2_ff;
    reg        low_s1_ff, low_s2_ff;

    always @(posedge i_clk_sys) begin
        por_s1_ff <= i_por_active;
        por_s2_ff <= por_s1_ff;
        ext_s1_ff <= i_ext_rst_n;
        ext_s2_ff <= ext_s1_ff;
        low_s1_ff <= i_supply_low;
        low_s2_ff <= low_s1_ff;
    end

    // ------------------------------------------------------------------
    // Power-on tracking
    // ------------------------------------------------------------------
    reg        por_done_ff;
    reg        por_prev_ff;
    reg        ext_prev_ff;
    wire       por_gate;
    wire       por_sync_act;

    // Only the synchronised detector is read, as for the other pins
    assign por_gate     = por_sync_act;
    assign por_sync_act = por_s2_ff & ~por_done_ff;

    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            por_done_ff <= 1'b0;
            por_prev_ff <= 1'b0;
            ext_prev_ff <= 1'b1;
        end else begin
            por_prev_ff <= por_sync_act;
            ext_prev_ff <= ext_s2_ff;
            if (por_prev_ff && !por_sync_act)
                por_done_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    reg  [31:0]               srst0_ff, srst1_ff, srst2_ff;
    reg  [1:0]                supctl_ff;
    reg  [`RSC_CAUSE_W-1:0]   cause_ff;
    reg  [31:0]               wdload_ff;
    reg  [31:0]               wdcnt_ff;
    reg  [1:0]                wdctl_ff;
    reg                       wdflag_ff;
    reg  [`RSC_PULSE_CW-1:0]  pulse_cnt_ff;
    reg                       drop_hold_ff;
    reg                       core_s1_ff, core_rst_n_ff;
    reg                       tap_s1_ff, tap_rst_n_ff;
    reg  [2:0]                boot_ff;
    reg  [2:0]                nxt_boot;

    localparam [31:0] PULSE_LOAD = `RSC_PULSE_CYC;

    wire       soft_rst;
    wire       wr_sysreq;
    wire       wd_zero;
    wire       wd_fire;
    wire       drop_rst_cond;
    wire       rst_raw;

    // Software-owned state follows the combined internal reset
    assign soft_rst  = !i_resetn || !core_rst_n_ff;
    assign wr_sysreq = i_wr && hit(i_addr, `RSC_OFS_SYSREQ) &&
                       i_wdata[`RSC_SYSREQ_BIT];
    assign wd_zero   = (wdcnt_ff == `RSC_ZERO32);
    assign wd_fire   = wdctl_ff[`RSC_WDCTL_EN] && wd_zero && wdflag_ff &&
                       wdctl_ff[`RSC_WDCTL_RSTEN];
    assign drop_rst_cond = supctl_ff[`RSC_SUP_EN] &&
                           supctl_ff[`RSC_SUP_RSTSEL] && low_s2_ff;

    always @(posedge i_clk_sys) begin
        if (soft_rst) begin
            srst0_ff  <= `RSC_ZERO32;
            srst1_ff  <= `RSC_ZERO32;
            srst2_ff  <= `RSC_ZERO32;
            supctl_ff <= `RSC_SUPCTL_RST;
        end else if (i_wr) begin
            if (hit(i_addr, `RSC_OFS_SRST0))
                srst0_ff <= i_wdata;
            if (hit(i_addr, `RSC_OFS_SRST1))
                srst1_ff <= i_wdata;
            if (hit(i_addr, `RSC_OFS_SRST2))
                srst2_ff <= i_wdata;
            if (hit(i_addr, `RSC_OFS_SUPCTL))
                supctl_ff <= i_wdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Supply-drop response
    // ------------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            drop_hold_ff      <= 1'b0;
            o_supply_drop_irq <= 1'b0;
        end else begin
            // Hold survives the reset it causes, released on recovery
            if (drop_rst_cond)
                drop_hold_ff <= 1'b1;
            else if (!low_s2_ff)
                drop_hold_ff <= 1'b0;
            o_supply_drop_irq <= supctl_ff[`RSC_SUP_EN] &&
                                 !supctl_ff[`RSC_SUP_RSTSEL] &&
                                 low_s2_ff;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (soft_rst) begin
            wdload_ff <= `RSC_WDLOAD_RST;
            wdcnt_ff  <= `RSC_WDLOAD_RST;
            wdctl_ff  <= `RSC_WDCTL_RST;
            wdflag_ff <= 1'b0;
        end else begin
            if (i_wr && hit(i_addr, `RSC_OFS_WDCTL))
                wdctl_ff <= i_wdata[1:0];
            if (i_wr && hit(i_addr, `RSC_OFS_WDLOAD)) begin
                wdload_ff <= i_wdata;
                wdcnt_ff  <= i_wdata;
            end else if (wdctl_ff[`RSC_WDCTL_EN]) begin
                if (wd_zero)
                    wdcnt_ff <= wdload_ff;
                else
                    wdcnt_ff <= wdcnt_ff - 32'h0000_0001;
            end
            // A time-out in the clearing cycle keeps the flag set
            if (wdctl_ff[`RSC_WDCTL_EN] && wd_zero)
                wdflag_ff <= 1'b1;
            else if (i_wr && hit(i_addr, `RSC_OFS_WDICR))
                wdflag_ff <= 1'b0;
        end
    end

    always @(posedge i_clk_sys) begin
        if (soft_rst)
            o_wdt_irq <= 1'b0;
        else
            o_wdt_irq <= wdflag_ff;
    end

    // ------------------------------------------------------------------
    // Reset pulse for software and watchdog requests
    // ------------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (!i_resetn)
            pulse_cnt_ff <= {`RSC_PULSE_CW{1'b0}};
        else if (wr_sysreq || wd_fire)
            pulse_cnt_ff <= PULSE_LOAD[`RSC_PULSE_CW-1:0];
        else if (pulse_cnt_ff != {`RSC_PULSE_CW{1'b0}})
            pulse_cnt_ff <= pulse_cnt_ff - 4'h1;
    end

    // ------------------------------------------------------------------
    // Combined reset, asynchronous assert and clocked release
    // ------------------------------------------------------------------
    assign rst_raw = !i_resetn || por_gate || !ext_s2_ff ||
                     drop_hold_ff ||
                     (pulse_cnt_ff != {`RSC_PULSE_CW{1'b0}});

    always @(posedge i_clk_sys or posedge rst_raw) begin
        if (rst_raw) begin
            core_s1_ff    <= 1'b0;
            core_rst_n_ff <= 1'b0;
        end else begin
            core_s1_ff    <= 1'b1;
            core_rst_n_ff <= core_s1_ff;
        end
    end

    // Test-access reset follows power-on only
    wire tap_raw;
    assign tap_raw = !i_resetn || por_gate;

    always @(posedge i_clk_sys or posedge tap_raw) begin
        if (tap_raw) begin
            tap_s1_ff    <= 1'b0;
            tap_rst_n_ff <= 1'b0;
        end else begin
            tap_s1_ff    <= 1'b1;
            tap_rst_n_ff <= tap_s1_ff;
        end
    end

    assign o_core_rst_n = core_rst_n_ff;
    assign o_tap_rst_n  = tap_rst_n_ff;

    // ------------------------------------------------------------------
    // Peripheral resets, one line per unit covering all its clocks
    // ------------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        if (soft_rst)
            o_periph_rst_n <= {96{1'b0}};
        else
            o_periph_rst_n <= ~{srst2_ff, srst1_ff, srst0_ff};
    end

    // ------------------------------------------------------------------
    // Reset cause flags
    // ------------------------------------------------------------------
    reg [`RSC_CAUSE_W-1:0] nxt_cause;
    reg [`RSC_CAUSE_W-1:0] cause_set;

    always @* begin
        cause_set = `RSC_CAUSE_RST;
        cause_set[`RSC_CAUSE_DROP] = drop_rst_cond && !drop_hold_ff;
        cause_set[`RSC_CAUSE_WDT]  = wd_fire;
        cause_set[`RSC_CAUSE_SW]   = wr_sysreq;
        nxt_cause = cause_ff;
        if (i_wr && hit(i_addr, `RSC_OFS_CAUSE))
            nxt_cause = cause_ff & ~i_wdata[`RSC_CAUSE_W-1:0];
        nxt_cause = nxt_cause | cause_set;
        if (por_sync_act && !por_prev_ff) begin
            nxt_cause = `RSC_CAUSE_RST;
            nxt_cause[`RSC_CAUSE_POR] = 1'b1;
        end else if (!ext_s2_ff && ext_prev_ff) begin
            nxt_cause = `RSC_CAUSE_RST;
            nxt_cause[`RSC_CAUSE_EXT] = 1'b1;
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_resetn)
            cause_ff <= `RSC_CAUSE_RST;
        else
            cause_ff <= nxt_cause;
    end

    // ------------------------------------------------------------------
    // Boot fetch sequencer
    // ------------------------------------------------------------------
    always @* begin
        case (boot_ff)
            ST_HOLD: nxt_boot = ST_SP;
            ST_SP:   nxt_boot = ST_PC;
            ST_PC:   nxt_boot = ST_INSN;
            ST_INSN: nxt_boot = ST_RUN;
            ST_RUN:  nxt_boot = ST_RUN;
            default: nxt_boot = ST_HOLD;
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (soft_rst) begin
            boot_ff       <= ST_HOLD;
            o_fetch_valid <= 1'b0;
            o_fetch_kind  <= `RSC_FETCH_SP;
            o_cpu_run     <= 1'b0;
        end else begin
            boot_ff       <= nxt_boot;
            o_fetch_valid <= (nxt_boot == ST_SP) || (nxt_boot == ST_PC) ||
                             (nxt_boot == ST_INSN);
            o_cpu_run     <= (nxt_boot == ST_RUN);
            case (nxt_boot)
                ST_PC:   o_fetch_kind <= `RSC_FETCH_PC;
                ST_INSN: o_fetch_kind <= `RSC_FETCH_INSN;
                default: o_fetch_kind <= `RSC_FETCH_SP;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    reg [31:0] nxt_rdata;

    always @* begin
        nxt_rdata = `RSC_ZERO32;
        case (i_addr)
            `RSC_OFS_SRST0:   nxt_rdata = srst0_ff;
            `RSC_OFS_SRST1:   nxt_rdata = srst1_ff;
            `RSC_OFS_SRST2:   nxt_rdata = srst2_ff;
            `RSC_OFS_SUPCTL:  nxt_rdata[1:0] = supctl_ff;
            `RSC_OFS_CAUSE:   nxt_rdata[`RSC_CAUSE_W-1:0] = cause_ff;
            `RSC_OFS_WDLOAD:  nxt_rdata = wdload_ff;
            `RSC_OFS_WDVALUE: nxt_rdata = wdcnt_ff;
            `RSC_OFS_WDCTL:   nxt_rdata[1:0] = wdctl_ff;
            `RSC_OFS_WDICR:   nxt_rdata[`RSC_WDICR_FLAG] = wdflag_ff;
            `RSC_OFS_STATUS: begin
                nxt_rdata[`RSC_ST_DROP_IRQ] = o_supply_drop_irq;
                nxt_rdata[`RSC_ST_CORE_RUN] = o_cpu_run;
                nxt_rdata[`RSC_ST_TAP_RUN]  = tap_rst_n_ff;
            end
            default:          nxt_rdata = `RSC_ZERO32;
        endcase
    end

    always @(posedge i_clk_sys) begin
        if (!i_resetn)
            o_rdata <= `RSC_ZERO32;
        else if (i_rd)
            o_rdata <= nxt_rdata;
        else
            o_rdata <= `RSC_ZERO32;
    end

endmodule

// *** rsc_reset_ctrl_asserts.sv ***
// Concurrent checks on the ports of the reset source controller.
// Assumes it is bound to rsc_reset_ctrl and sees only its ports.
`timescale 1ns/10ps
`include "rsc_regs.vh"

module rsc_reset_ctrl_chk (
    // Clock and reset
    input wire                   i_clk_sys,
    input wire                   i_resetn,
    // Reset sources
    input wire                   i_por_active,
    input wire                   i_ext_rst_n,
    input wire                   i_supply_low,
    // Register port
    input wire [`RSC_ADDR_W-1:0] i_addr,
    input wire [31:0]            i_wdata,
    input wire                   i_wr,
    input wire                   i_rd,
    input wire [31:0]            o_rdata,
    // Outputs watched
    input wire                   o_core_rst_n,
    input wire                   o_tap_rst_n,
    input wire [95:0]            o_periph_rst_n,
    input wire                   o_fetch_valid,
    input wire [1:0]             o_fetch_kind,
    input wire                   o_cpu_run,
    input wire                   o_supply_drop_irq,
    input wire                   o_wdt_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    a_tap_kept: assert property (o_tap_rst_n |=> o_tap_rst_n)
        else $error("test port reset asserted after power-up");
    a_rd_idle: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
        else $error("read data not zero outside read answer");
    a_periph_map: assert property (i_wr && o_core_rst_n
        && i_addr == `RSC_OFS_SRST0 |=> ##1
        o_periph_rst_n[31:0] == ~$past(i_wdata, 2))
        else $error("peripheral resets do not follow soft reset bits");
    a_sysreq_pulse: assert property (i_wr && o_core_rst_n
        && i_addr == `RSC_OFS_SYSREQ && i_wdata[0]
        |=> !o_core_rst_n [*8] ##[1:4] o_core_rst_n)
        else $error("system request reset pulse wrong");
    a_boot_seq: assert property ($rose(o_core_rst_n) |=>
        o_fetch_valid && o_fetch_kind == `RSC_FETCH_SP
        ##1 o_fetch_valid && o_fetch_kind == `RSC_FETCH_PC
        ##1 o_fetch_valid && o_fetch_kind == `RSC_FETCH_INSN
        ##1 !o_fetch_valid && o_cpu_run)
        else $error("boot fetch sequence wrong");
    a_run_reset: assert property (!o_core_rst_n |=> !o_cpu_run)
        else $error("core runs while in reset");
    a_pin_core: assert property (!i_ext_rst_n [*4] |-> !o_core_rst_n)
        else $error("pin low did not reset the core");
    a_drop_irq_off: assert property (!i_supply_low [*4]
        |-> !o_supply_drop_irq)
        else $error("supply drop event with supply good");
    a_wd_clear: assert property (i_wr && o_core_rst_n
        && i_addr == `RSC_OFS_WDICR |=> ##1 !o_wdt_irq)
        else $error("watchdog flag not cleared by write");
endmodule

bind rsc_reset_ctrl rsc_reset_ctrl_chk u_chk (.i_clk_sys, .i_resetn,
    .i_por_active, .i_ext_rst_n, .i_supply_low, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_core_rst_n, .o_tap_rst_n, .o_periph_rst_n,
    .o_fetch_valid, .o_fetch_kind, .o_cpu_run, .o_supply_drop_irq,
    .o_wdt_irq);

// *** rsc_ext_model.sv ***
// Reset pin circuitry and supply monitors outside the controller.
// Assumes the bench commands switch presses, sags and detector misfires.
`timescale 1ns/10ps

module rsc_ext_model #(
    parameter POR_CYC = 6,
    parameter PIN_MIN = 6
) (
    // Clock and bench reset
    input  wire  i_clk_sys,
    input  wire  i_resetn,
    // Commands from the bench
    input  wire  i_press,
    input  wire  i_sag,
    input  wire  i_por_glitch,
    // Lines into the controller
    output logic o_por_active,
    output logic o_ext_rst_n,
    output logic o_supply_low
);
    int por_cnt = POR_CYC;
    int pin_cnt = 0;
    // Detector fires once at power-up; a misfire only when commanded
    always @(posedge i_clk_sys) begin
        if (i_resetn && por_cnt != 0)
            por_cnt <= por_cnt - 1;
        else if (i_por_glitch)
            por_cnt <= 2;
        o_por_active <= (por_cnt != 0);
    end
    // Switch holds the pin low for the minimum time, then releases
    always @(posedge i_clk_sys) begin
        if (i_press)
            pin_cnt <= PIN_MIN;
        else if (pin_cnt != 0)
            pin_cnt <= pin_cnt - 1;
        o_ext_rst_n <= (pin_cnt == 0);
    end
    always @(posedge i_clk_sys)
        o_supply_low <= i_sag;
endmodule

// *** tb_reset_source_controller.sv ***
// Bench for the reset source controller with its outside model.
// Assumes a 10 MHz clock and a one-cycle strobe register port.
`timescale 1ns/10ps
`include "rsc_regs.vh"

module tb_reset_source_controller;
    logic                   i_clk_sys = 1'b0;
    logic                   i_resetn = 1'b0;
    logic [`RSC_ADDR_W-1:0] i_addr = '0;
    logic [31:0]            i_wdata = '0;
    logic                   i_wr = 1'b0;
    logic                   i_rd = 1'b0;
    logic                   press = 1'b0;
    logic                   sag = 1'b0;
    logic                   glitch = 1'b0;
    wire                    por_active, ext_rst_n, supply_low;
    wire  [31:0]            o_rdata;
    wire                    o_core_rst_n, o_tap_rst_n, o_fetch_valid;
    wire  [95:0]            o_periph_rst_n;
    wire  [1:0]             o_fetch_kind;
    wire                    o_cpu_run, o_supply_drop_irq, o_wdt_irq;
    int                     num_errors = 0;
    int                     num_checks = 0;

    always #50 i_clk_sys = ~i_clk_sys;

    rsc_ext_model u_ext (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_press(press), .i_sag(sag), .i_por_glitch(glitch),
        .o_por_active(por_active), .o_ext_rst_n(ext_rst_n),
        .o_supply_low(supply_low));

    rsc_reset_ctrl DUT (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
        .i_por_active(por_active), .i_ext_rst_n(ext_rst_n),
        .i_supply_low(supply_low), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_core_rst_n(o_core_rst_n), .o_tap_rst_n(o_tap_rst_n),
        .o_periph_rst_n(o_periph_rst_n), .o_fetch_valid(o_fetch_valid),
        .o_fetch_kind(o_fetch_kind), .o_cpu_run(o_cpu_run),
        .o_supply_drop_irq(o_supply_drop_irq), .o_wdt_irq(o_wdt_irq));

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk(nm, e, o_rdata);
    endtask

    // Wait on 0 cpu_run, 1 core reset, 2 watchdog flag
    task automatic wait_for(input int w, input logic v);
        logic s;
        for (int n = 0; n < 300; n++) begin
            @(posedge i_clk_sys);
            #1;
            case (w)
                0: s = o_cpu_run;
                1: s = o_core_rst_n;
                default: s = o_wdt_irq;
            endcase
            if (s === v)
                return;
        end
        num_errors++;
        $display("MISMATCH wait %0d expected %b seen timeout", w, v);
        wrap_up();
    endtask

    initial begin
        repeat (5) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk("por core", 0, o_core_rst_n);
        chk("por tap", 0, o_tap_rst_n);
        wait_for(0, 1'b1);
        chk("tap up", 1, o_tap_rst_n);
        rd("cause por", `RSC_OFS_CAUSE, 32'h0000_0001);
        rd("supctl rst", `RSC_OFS_SUPCTL, 32'h0000_0000);
        sag <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        #1;
        chk("drop off", 0, o_supply_drop_irq);
        chk("drop off core", 1, o_core_rst_n);
        sag <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            wr(8'(k * 4), 32'hA5A5_0F0F ^ k);
            @(posedge i_clk_sys);
            #1;
            chk("periph set", ~(32'hA5A5_0F0F ^ k),
                o_periph_rst_n[k*32 +: 32]);
            rd("srst back", 8'(k * 4), 32'hA5A5_0F0F ^ k);
            wr(8'(k * 4), 32'h0000_0000);
            @(posedge i_clk_sys);
            #1;
            chk("periph clr", 32'hFFFF_FFFF, o_periph_rst_n[k*32 +: 32]);
        end
        rd("unmapped", 8'hFC, 32'h0000_0000);
        wr(`RSC_OFS_SUPCTL, 32'h0000_0001);
        sag <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
        #1;
        chk("drop irq", 1, o_supply_drop_irq);
        chk("drop no rst", 1, o_core_rst_n);
        sag <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        #1;
        chk("drop irq off", 0, o_supply_drop_irq);
        wr(`RSC_OFS_SUPCTL, 32'h0000_0003);
        sag <= 1'b1;
        wait_for(1, 1'b0);
        repeat (20) @(posedge i_clk_sys);
        #1;
        chk("drop hold", 0, o_core_rst_n);
        sag <= 1'b0;
        wait_for(0, 1'b1);
        rd("supctl off", `RSC_OFS_SUPCTL, 32'h0000_0000);
        rd("cause drop", `RSC_OFS_CAUSE, 32'h0000_0005);
        wr(`RSC_OFS_SYSREQ, 32'h0000_0001);
        wait_for(1, 1'b0);
        wait_for(0, 1'b1);
        rd("cause sw", `RSC_OFS_CAUSE, 32'h0000_0015);
        wr(`RSC_OFS_WDLOAD, 32'h0000_0014);
        wr(`RSC_OFS_WDCTL, 32'h0000_0003);
        wait_for(2, 1'b1);
        chk("wd first", 1, o_core_rst_n);
        rd("wd reload", `RSC_OFS_WDVALUE, 32'h0000_0012);
        wr(`RSC_OFS_WDICR, 32'h0000_0001);
        wait_for(2, 1'b1);
        chk("wd serviced", 1, o_core_rst_n);
        wait_for(1, 1'b0);
        wait_for(0, 1'b1);
        rd("cause wdt", `RSC_OFS_CAUSE, 32'h0000_001D);
        press <= 1'b1;
        @(posedge i_clk_sys);
        press <= 1'b0;
        wait_for(1, 1'b0);
        wait_for(0, 1'b1);
        chk("pin tap", 1, o_tap_rst_n);
        rd("cause pin", `RSC_OFS_CAUSE, 32'h0000_0002);
        glitch <= 1'b1;
        @(posedge i_clk_sys);
        glitch <= 1'b0;
        repeat (10) @(posedge i_clk_sys);
        #1;
        chk("por again", 1, o_core_rst_n);
        rd("cause kept", `RSC_OFS_CAUSE, 32'h0000_0002);
        wrap_up();
    end
endmodule
